/* verilog/pac_pkg.sv */
// ************************************************************
// Pulse accumulator constants
// ************************************************************
package pac_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h06;
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_FLAGS = 8'h21;
  localparam logic [7:0] ADDR_COUNT = 8'h22;

  // Field positions in accumulator_control
  localparam int CTRL_ENABLE = 6;
  localparam int CTRL_MODE = 5;
  localparam int CTRL_EDGE = 4;
  localparam int CTRL_CLK_HI = 3;
  localparam int CTRL_CLK_LO = 2;
  localparam int CTRL_OVF_IE = 1;
  localparam int CTRL_IN_IE = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h7f;

  // Field positions in accumulator_flags
  localparam int FLAG_OVF = 1;
  localparam int FLAG_IN = 0;

  // Field positions in timer_system_control_one
  localparam int SYS_TIMER_EN = 7;
  localparam int SYS_FAST_CLR = 4;
  localparam logic [7:0] SYS_WMASK = 8'h90;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SYS_RESET = 8'h00;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Gated time base: bus clock divided by 64
  localparam int GATE_DIV = 64;
  localparam logic [5:0] GATE_DIV_LAST = 6'(GATE_DIV - 1);

  // Timer counter clock sources
  localparam logic [1:0] SRC_PRESCALE = 2'h0;
  localparam logic [1:0] SRC_ACC = 2'h1;
  localparam logic [1:0] SRC_ACC_256 = 2'h2;
  localparam logic [1:0] SRC_ACC_64K = 2'h3;

  // Address match for a register port access
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] offs);
    reg_hit = (addr == offs);
  endfunction : reg_hit

endpackage : pac_pkg

/* verilog/pac_pin_if.sv */
`timescale 1ns/1ps
// ************************************************************
// Synchronised pin level and edges
// ************************************************************
interface pac_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport snk (input level, input rise, input fall);
endinterface : pac_pin_if

/* verilog/pac_input_sync.sv */
`timescale 1ns/1ps
// ************************************************************
// Channel 7 pin synchroniser and edge detector
// ************************************************************
module pac_input_sync (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic pin_i,
  pac_pin_if.src pin_o
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // Three flops; the first one feeds only the second
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else if (ce)
    begin
      meta_r <= pin_i; // see RULE18
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Edges come from settled flops only, so counts lag the pin
  assign pin_o.level = sync_r;
  assign pin_o.rise = sync_r & ~last_r;
  assign pin_o.fall = ~sync_r & last_r;

  // ************************************************************
  // Checks
  // ************************************************************
  // Pin low then high on two running edges
  sequence pin_went_high;
    ce && !pin_i ##1 ce && pin_i ##1 ce;
  endsequence

  sync_rise_a: assert property (@(posedge mclk) disable iff (reset) // see RULE18
    pin_went_high |=> pin_o.rise)
    else $error("rise pulse missing two edges after pin rose");

endmodule : pac_input_sync

/* verilog/pac_control.sv */
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
// ************************************************************
// Summary of operation
// RULE1: enable bit works independent of timer enable
// RULE2: input shares the channel 7 pin
// RULE3: mode 0 counts events, 1 gates time
// RULE4: edge bit 0 falling, 1 rising count
// RULE5: gated, edge 0: high gates clock/64
// RULE6: gated, edge 1: low gates clock/64
// RULE7: clock/64 absent while timer disabled
// RULE8: clock select picks timer counter source
// RULE9: accumulator off forces prescaler source
// RULE10: clock select change acts immediately
// RULE11: overflow enable gates overflow interrupt
// RULE12: input enable gates input edge interrupt
// RULE13: overflow flag sets on count wrap
// RULE14: event mode edge sets input flag
// RULE15: write-one clears, only while something enabled
// RULE16: fast clear on count access clears flags
// RULE17: 16-bit count readable, writable any time
// RULE18: pin synchronised before counting
// RULE19: zero write keeps flag; irq is AND
// ************************************************************
module pac_control (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic CHANNEL7_PIN,
  input wire logic PRESCALE_TICK,
  output logic TCNT_TICK,
  output logic ACC_CLK_TICK,
  output logic OVF_IRQ,
  output logic IN_IRQ,
  output logic IRQ
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0] ctrl_r;
  logic [7:0] sys_r;
  logic [1:0] flags_r;
  logic [1:0] flags_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [5:0] div_r;
  logic [15:0] rdata_nxt;
  logic tick_nxt;

  logic acc_en;
  logic acc_mode;
  logic acc_edge;
  logic [1:0] clk_sel;
  logic timer_en;
  logic fast_clr;
  logic div_tick;
  logic in_evt;
  logic gate_on;
  logic acc_clk;
  logic count_wr;
  logic count_hit;
  logic wrap;
  logic clr_ok;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;

  pac_pin_if pin_bus ();

  // ************************************************************
  // Pin input
  // ************************************************************
  // Input taken from the channel 7 pin, not a pin of its own
  pac_input_sync u_sync ( // see RULE2
    .mclk (MCLK),
    .reset (RESET),
    .ce (CE),
    .pin_i (CHANNEL7_PIN),
    .pin_o (pin_bus.src)
  );

  // ************************************************************
  // Control registers
  // ************************************************************
  // Field views
  assign acc_en = ctrl_r[pac_pkg::CTRL_ENABLE];
  assign acc_mode = ctrl_r[pac_pkg::CTRL_MODE];
  assign acc_edge = ctrl_r[pac_pkg::CTRL_EDGE];
  assign clk_sel = ctrl_r[pac_pkg::CTRL_CLK_HI:pac_pkg::CTRL_CLK_LO];
  assign timer_en = sys_r[pac_pkg::SYS_TIMER_EN];
  assign fast_clr = sys_r[pac_pkg::SYS_FAST_CLR];

  // Accumulator control, written any time
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      ctrl_r <= pac_pkg::CTRL_RESET;
    else if (CE && WR && pac_pkg::reg_hit(ADDR, pac_pkg::ADDR_CTRL))
      ctrl_r <= WDATA[7:0] & pac_pkg::CTRL_WMASK;
  end

  // Timer enable and fast clear live here
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      sys_r <= pac_pkg::SYS_RESET;
    else if (CE && WR && pac_pkg::reg_hit(ADDR, pac_pkg::ADDR_SYS_CTRL))
      sys_r <= WDATA[7:0] & pac_pkg::SYS_WMASK;
  end

  // ************************************************************
  // Gated time base
  // ************************************************************
  // Stands in for the prescaler tap, so it stops with the timer
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      div_r <= 6'h00;
    else if (CE)
    begin
      if (timer_en)
        div_r <= div_r + 6'h01;
      else
        div_r <= 6'h00; // see RULE7
    end
  end

  assign div_tick = timer_en && (div_r == pac_pkg::GATE_DIV_LAST); // see RULE7

  // ************************************************************
  // Accumulator clock
  // ************************************************************
  // Selected edge; enable is independent of the timer enable
  assign in_evt = acc_en && (acc_edge ? pin_bus.rise // see RULE1
                                      : pin_bus.fall); // see RULE4

  // Gate level: high for edge 0, low for edge 1
  assign gate_on = acc_edge ? ~pin_bus.level // see RULE6
                            : pin_bus.level; // see RULE5

  // Mode only matters while enabled
  always_comb
  begin
    acc_clk = 1'b0;
    if (acc_en)
    begin
      if (acc_mode)
        acc_clk = div_tick && gate_on; // see RULE3
      else
        acc_clk = in_evt; // see RULE3
    end
  end

  // ************************************************************
  // Count register
  // ************************************************************
  assign count_wr = WR && pac_pkg::reg_hit(ADDR, pac_pkg::ADDR_COUNT);
  assign count_hit = count_wr ||
                     (RD && pac_pkg::reg_hit(ADDR, pac_pkg::ADDR_COUNT));
  // A software load beats a count in the same cycle
  assign wrap = acc_clk && !count_wr && (count_r == 16'hffff);

  // Next count value
  always_comb
  begin
    count_nxt = count_r;
    if (count_wr)
      count_nxt = WDATA; // see RULE17
    else if (acc_clk)
      count_nxt = count_r + 16'h0001; // see RULE17
  end

  // Count state
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      count_r <= pac_pkg::COUNT_RESET;
    else if (CE)
      count_r <= count_nxt;
  end

  // ************************************************************
  // Flags
  // ************************************************************
  // Clears only take hold while timer or accumulator runs
  assign clr_ok = timer_en || acc_en; // see RULE15

  // Flag set and clear terms
  always_comb
  begin
    flag_set = 2'h0;
    flag_set[pac_pkg::FLAG_OVF] = wrap; // see RULE13
    flag_set[pac_pkg::FLAG_IN] = in_evt; // see RULE14
    flag_clr = 2'h0;
    if (clr_ok && WR && pac_pkg::reg_hit(ADDR, pac_pkg::ADDR_FLAGS))
      flag_clr = WDATA[1:0]; // see RULE15
    if (clr_ok && fast_clr && count_hit)
      flag_clr = 2'h3; // see RULE16
    // Set wins over clear so no event is lost
    flags_nxt = (flags_r & ~flag_clr) | flag_set; // see RULE19
  end

  // Flag state
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      flags_r <= pac_pkg::FLAGS_RESET;
    else if (CE)
      flags_r <= flags_nxt;
  end

  // ************************************************************
  // Timer counter clock
  // ************************************************************
  // Reads the live select field, so a new source acts next cycle
  always_comb
  begin
    tick_nxt = PRESCALE_TICK;
    if (acc_en) // see RULE9
    begin
      case (clk_sel) // see RULE10
        pac_pkg::SRC_PRESCALE: tick_nxt = PRESCALE_TICK; // see RULE8
        pac_pkg::SRC_ACC: tick_nxt = acc_clk; // see RULE8
        pac_pkg::SRC_ACC_256:
          tick_nxt = acc_clk && (count_r[7:0] == 8'hff); // see RULE8
        pac_pkg::SRC_ACC_64K: tick_nxt = acc_clk && (count_r == 16'hffff);
        default: tick_nxt = PRESCALE_TICK;
      endcase
    end
  end

  // Tick outputs, one cycle behind their cause
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      TCNT_TICK <= 1'b0;
      ACC_CLK_TICK <= 1'b0;
    end
    else if (CE)
    begin
      TCNT_TICK <= tick_nxt;
      ACC_CLK_TICK <= acc_clk;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  // OVF_IRQ and IN_IRQ are each their flag ANDed with its enable; IRQ is the OR of both
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      OVF_IRQ <= 1'b0;
      IN_IRQ <= 1'b0;
      IRQ <= 1'b0;
    end
    else if (CE)
    begin
      OVF_IRQ <= flags_r[pac_pkg::FLAG_OVF] &&
                 ctrl_r[pac_pkg::CTRL_OVF_IE]; // see RULE11
      IN_IRQ <= flags_r[pac_pkg::FLAG_IN] &&
                ctrl_r[pac_pkg::CTRL_IN_IE]; // see RULE12
      IRQ <= |(flags_r & ctrl_r[1:0]); // see RULE19
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  // Unmapped reads return zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (RD)
    begin
      case (ADDR)
        pac_pkg::ADDR_CTRL: rdata_nxt = {8'h00, ctrl_r};
        pac_pkg::ADDR_FLAGS: rdata_nxt = {14'h0000, flags_r};
        pac_pkg::ADDR_COUNT: rdata_nxt = count_r; // see RULE17
        pac_pkg::ADDR_SYS_CTRL: rdata_nxt = {8'h00, sys_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      RDATA <= 16'h0000;
    else if (CE)
      RDATA <= rdata_nxt;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  sequence acc_step;
    CE && acc_clk && !count_wr;
  endsequence

  sequence gated_step;
    CE && acc_en && acc_mode && !acc_edge && div_tick &&
    pin_bus.level && !count_wr;
  endsequence

  acc_count_a: assert property (acc_step |=> // see RULE1
    count_r == $past(count_r) + 16'h0001)
    else $error("count did not advance on accumulator clock");

  gated_high_a: assert property (gated_step |=> // see RULE5
    count_r == $past(count_r) + 16'h0001 && ACC_CLK_TICK)
    else $error("high gate did not pass the time base");

  div_off_a: assert property (CE && acc_en && acc_mode && // see RULE7
    !timer_en && !count_wr |=> count_r == $past(count_r))
    else $error("gated count moved with timer disabled");

  ovf_irq_a: assert property (CE |=> // see RULE11
    OVF_IRQ == $past(flags_r[1] && ctrl_r[1]))
    else $error("overflow irq not flag AND enable");

  in_irq_a: assert property (CE |=> // see RULE12
    IN_IRQ == $past(flags_r[0] && ctrl_r[0]))
    else $error("input irq not flag AND enable");

  ovf_set_a: assert property (CE && acc_clk && !count_wr && // see RULE13
    count_r == 16'hffff |=> flags_r[1] && count_r == 16'h0000)
    else $error("wrap did not set overflow flag");

  edge_flag_a: assert property (CE && in_evt |=> flags_r[0]) // see RULE14
    else $error("input edge did not set input flag");

  clr_block_a: assert property (CE && WR && // see RULE15
    ADDR == pac_pkg::ADDR_FLAGS && !timer_en && !acc_en |=>
    flags_r == $past(flags_r))
    else $error("flag cleared while all disabled");

  fast_clr_a: assert property (CE && count_hit && fast_clr && // see RULE16
    clr_ok && !in_evt && !wrap |=> flags_r == 2'h0)
    else $error("count access did not clear flags");

  src_off_a: assert property (CE && !acc_en |=> // see RULE9
    TCNT_TICK == $past(PRESCALE_TICK))
    else $error("timer clock not prescaler while disabled");

  acc_src_a: assert property (CE && acc_en && // see RULE8
    clk_sel == pac_pkg::SRC_ACC |=> TCNT_TICK == ACC_CLK_TICK)
    else $error("timer clock not accumulator clock");

endmodule : pac_control

/* tb/pac_pin_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Outside signal on the shared channel 7 pin
// ************************************************************
module pac_pin_model (
  input wire logic mclk,
  output logic pin
);
  // Idles low until the first pulse
  initial pin = 1'b0;

  // Pulses of level lvl held for hi clocks, then ~lvl for lo; each level lasts at least one clock, so the
  // synchroniser never sees a pulse too short to catch
  task automatic pulse(input int n, input int hi, input int lo,
                       input logic lvl);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      pin <= lvl;
      repeat (hi) @(posedge mclk);
      pin <= ~lvl;
      repeat (lo) @(posedge mclk);
    end
  endtask : pulse
endmodule : pac_pin_model

/* tb/pulse_accumulator_control_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  error_cnt++; $display("BAD %0t got %0h want %0h", $time, (a), (b)); \
  end end
// ************************************************************
// Pulse accumulator control bench
// ************************************************************
module pulse_accumulator_control_tb_top;
  localparam logic [7:0] A_SYS = pac_pkg::ADDR_SYS_CTRL;
  localparam logic [7:0] A_CTL = pac_pkg::ADDR_CTRL;
  localparam logic [7:0] A_FLG = pac_pkg::ADDR_FLAGS;
  localparam logic [7:0] A_CNT = pac_pkg::ADDR_COUNT;
  logic mclk;
  logic reset;
  logic ce;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic pin;
  logic pre_tick;
  logic pre_q;
  logic pre_en;
  logic cmp_on;
  logic tcnt_tick;
  logic acc_tick;
  logic ovf_irq;
  logic in_irq;
  logic irq;
  logic [15:0] rd_v;
  int error_cnt;
  int check_count;
  int tc_n;
  int ac_n;
  logic [7:0] regs [5] = '{A_SYS, A_CTL, A_FLG, A_CNT, 8'h5a};
  logic [15:0] cs_ctl [3] = '{16'h0044, 16'h0048, 16'h004c};
  logic [15:0] cs_cnt [3] = '{16'h0000, 16'h00fe, 16'hfffe};
  int cs_tck [3] = '{3, 1, 1};
  logic [15:0] pre_ctl [3] = '{16'h0040, 16'h0004, 16'h000c};

  pac_control u_pac_control (
    .MCLK(mclk), .RESET(reset), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .CHANNEL7_PIN(pin),
    .PRESCALE_TICK(pre_tick), .TCNT_TICK(tcnt_tick),
    .ACC_CLK_TICK(acc_tick), .OVF_IRQ(ovf_irq), .IN_IRQ(in_irq),
    .IRQ(irq)
  );

  pac_pin_model u_pac_pin_model (
    .mclk(mclk),
    .pin(pin)
  );

  // 50 MHz bus clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Random prescaler ticks; pre_q keeps what the design sampled
  always @(posedge mclk)
  begin
    pre_q <= pre_tick;
    pre_tick <= pre_en & 1'($urandom_range(0, 1));
  end

  // Tick counts, and the prescaler pass-through compare
  always @(negedge mclk)
  begin
    tc_n += int'(tcnt_tick);
    ac_n += int'(acc_tick);
    if (cmp_on) `CHK(tcnt_tick, pre_q)
  end

  // Single-cycle write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read strobe; data stand only in the following cycle
  task automatic reg_rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    rd_v = rdata;
  endtask : reg_rd

  task automatic reg_chk(input logic [7:0] a, input logic [15:0] e);
    reg_rd(a);
    `CHK(rd_v, e)
  endtask : reg_chk

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // Watchdog cuts a hung run short
  initial
  begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    test_done();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    int n;
    logic [7:0] v;
    reset = 1'b1;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    pre_tick = 1'b0;
    pre_q = 1'b0;
    pre_en = 1'b0;
    cmp_on = 1'b0;
    error_cnt = 0;
    check_count = 0;
    tc_n = 0;
    ac_n = 0;
    void'($urandom(32'hdde497e9));
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    // Reset values, unmapped place reads zero
    foreach (regs[i]) reg_chk(regs[i], 16'h0000);
    v = 8'($urandom);
    reg_wr(A_CTL, {8'h00, v});
    reg_chk(A_CTL, {8'h00, v & pac_pkg::CTRL_WMASK});
    reg_wr(A_SYS, 16'h00ff);
    reg_chk(A_SYS, 16'h0090);
    reg_wr(A_SYS, 16'h0000);
    // Event counting on both edges, timer left off
    for (int e = 0; e < 2; e++)
    begin
      n = $urandom_range(1, 6);
      reg_wr(A_CTL, 16'h0041 | 16'(e << 4));
      reg_wr(A_CNT, 16'h0000);
      reg_wr(A_FLG, 16'h0003);
      u_pac_pin_model.pulse(n, 3, 3, 1'b1);
      repeat (5) @(posedge mclk);
      reg_chk(A_CNT, 16'(n));
      reg_chk(A_FLG, 16'h0001);
      `CHK(in_irq, 1'b1)
    end
    // Masking, zero writes, clear needs an enable
    reg_wr(A_CTL, 16'h0050);
    repeat (2) @(posedge mclk);
    #1;
    `CHK(in_irq, 1'b0)
    `CHK(irq, 1'b0)
    reg_wr(A_FLG, 16'h0000);
    reg_chk(A_FLG, 16'h0001);
    reg_wr(A_CTL, 16'h0000);
    reg_wr(A_FLG, 16'h0001);
    reg_chk(A_FLG, 16'h0001);
    reg_wr(A_CTL, 16'h0040);
    reg_wr(A_FLG, 16'h0001);
    reg_chk(A_FLG, 16'h0000);
    // Wrap from all ones sets the overflow flag
    reg_wr(A_CTL, 16'h0052);
    reg_wr(A_CNT, 16'hffff);
    u_pac_pin_model.pulse(1, 3, 3, 1'b1);
    repeat (3) @(posedge mclk);
    reg_chk(A_CNT, 16'h0000);
    reg_chk(A_FLG, 16'h0003);
    `CHK(ovf_irq, 1'b1)
    `CHK(in_irq, 1'b0)
    `CHK(irq, 1'b1)
    // Fast clear on a count access
    reg_wr(A_SYS, 16'h0010);
    reg_chk(A_CNT, 16'h0000);
    reg_chk(A_FLG, 16'h0000);
    reg_wr(A_SYS, 16'h0000);
    // Accumulator clock, divided by 256 and by 65536
    foreach (cs_ctl[i])
    begin
      reg_wr(A_CTL, cs_ctl[i]);
      reg_wr(A_CNT, cs_cnt[i]);
      tc_n = 0;
      ac_n = 0;
      u_pac_pin_model.pulse(3, 3, 3, 1'b1);
      repeat (4) @(posedge mclk);
      `CHK(tc_n, cs_tck[i])
      `CHK(ac_n, 3)
    end
    // Prescaler source, also forced while disabled
    pre_en <= 1'b1;
    foreach (pre_ctl[i])
    begin
      reg_wr(A_CNT, 16'h0000);
      reg_wr(A_CTL, pre_ctl[i]);
      @(posedge mclk);
      cmp_on = 1'b1;
      repeat (40) @(posedge mclk);
      cmp_on = 1'b0;
    end
    pre_en <= 1'b0;
    // Gated time accumulation at both gate levels
    reg_wr(A_SYS, 16'h0080);
    for (int e = 0; e < 2; e++)
    begin
      if (e == 1)
        u_pac_pin_model.pulse(1, 1, 4, 1'b0);
      reg_wr(A_CTL, 16'h0060 | 16'(e << 4));
      reg_wr(A_CNT, 16'h0000);
      reg_wr(A_FLG, 16'h0003);
      u_pac_pin_model.pulse(1, 196, 6, e == 0);
      reg_rd(A_CNT);
      `CHK(rd_v == 16'h0003 || rd_v == 16'h0004, 1'b1)
      reg_chk(A_FLG, 16'h0001);
    end
    // No time base while the timer is off
    reg_wr(A_SYS, 16'h0000);
    reg_wr(A_CNT, 16'h0000);
    u_pac_pin_model.pulse(1, 200, 6, 1'b0);
    reg_chk(A_CNT, 16'h0000);
    // Clock enable low: a count write is ignored
    @(posedge mclk);
    ce <= 1'b0;
    reg_wr(A_CNT, 16'h1234);
    ce <= 1'b1;
    reg_chk(A_CNT, 16'h0000);
    // Mid-run reset puts the registers back to rest
    reg_wr(A_CNT, 16'h00a5);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    reg_chk(A_CTL, 16'h0000);
    reg_chk(A_CNT, 16'h0000);
    test_done();
  end
endmodule : pulse_accumulator_control_tb_top
